// >>> common/ccu_cfg.svh
// constants for the coherency control unit control register
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH

// register location inside the unit map
`define CCU_CTRL_OFFSET    8'h00

// field positions of the control register
`define CCU_BIT_ENABLE     0
`define CCU_BIT_FILTER     1
`define CCU_BIT_TAG_ECC    2
`define CCU_BIT_SPEC_LF    3
`define CCU_BIT_STANDBY    5
`define CCU_BIT_IC_STANDBY 6
`define CCU_BIT_ECC_M0     12
`define CCU_BIT_ECC_M1     13
`define CCU_BIT_ECC_PERIPH 14
`define CCU_BIT_ECC_ACP    15

// reset value and masks
`define CCU_CTRL_RESET     32'h0000_0000
`define CCU_CTRL_WR_MASK   32'h0000_F06D
`define CCU_BYTE_W         8

`endif

// >>> common/ccu_pkg.sv
// types shared by the coherency control unit control logic
package ccu_pkg;

  // clock standby state, one-hot
  typedef enum logic [1:0] {
    CCU_RUN   = 2'b01,
    CCU_GATED = 2'b10
  } ccu_standby_e;

  // full control register word
  typedef logic [31:0] ccu_word_t;

endpackage

// >>> rtl/ccu_ctrl_reg.sv
// control register of the coherency control unit and its effects
`include "ccu_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ccu_ctrl_reg #(
  parameter bit ECC_IMPL    = 1'b1, // tag RAM ECC built in
  parameter bit TWO_MASTERS = 1'b1, // second master port built in
  parameter bit ACP_IMPL    = 1'b1, // accelerator port built in
  parameter bit L2_PRESENT  = 1'b1  // matching level-2 controller fitted
) (
  // clock, reset and clock enable
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // memory-mapped access from the processors
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic [7:0]  acc_addr,
  input  wire logic [3:0]  acc_be,
  input  wire logic [31:0] acc_wdata,
  input  wire logic        acc_cpu,
  input  wire logic [1:0]  access_ctrl,
  output var  logic [31:0] acc_rdata,
  output var  logic        acc_ack,
  // strap sampled at reset release
  input  wire logic        master_filter_enable_input,
  // activity for unit standby
  input  wire logic [1:0]  cpu_wait_for_interrupt_state,
  input  wire logic        accel_req_pending,
  input  wire logic        accel_new_req,
  input  wire logic        unit_busy,
  // activity for interrupt controller standby
  input  wire logic        irq_pending,
  input  wire logic [1:0]  cpu_rw_pending,
  // accelerator port readies from the datapath
  input  wire logic        accel_rd_addr_ready_in,
  input  wire logic        accel_wr_addr_ready_in,
  input  wire logic        accel_wr_data_ready_in,
  output var  logic        accel_port_read_addr_ready,
  output var  logic        accel_port_write_addr_ready,
  output var  logic        accel_port_write_data_ready,
  // coherent linefill and tag lookup
  input  wire logic        lf_req,
  input  wire logic        lf_to_m1,
  input  wire logic        lookup_done,
  input  wire logic        lookup_miss,
  output var  logic        spec_lf_m0,
  output var  logic        spec_lf_m1,
  output var  logic        confirm_lf_m0,
  output var  logic        confirm_lf_m1,
  // control outputs
  output var  logic        unit_enable,
  output var  logic        tag_ecc_enable,
  output var  logic        filter_on,
  output var  logic        ecc_chk_acp,
  output var  logic        ecc_chk_periph,
  output var  logic        ecc_chk_m1,
  output var  logic        ecc_chk_m0,
  output var  logic        unit_clk_en,
  output var  logic        interrupt_ctrl_clk_en
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  ccu_pkg::ccu_word_t ctrl;          // writable control bits
  ccu_pkg::ccu_word_t next_ctrl;     // next control bits
  ccu_pkg::ccu_word_t rd_word;       // word seen by a read
  ccu_pkg::ccu_word_t wr_merge;      // write data merged per byte
  logic               filt_flag;     // captured filtering flag
  logic               next_filt_flag;
  logic               filt_taken;    // strap has been captured
  logic               next_filt_taken;
  logic [31:0]        next_rdata;    // next read data
  logic               next_ack;      // next access acknowledge
  logic               hit;           // access hits this register
  logic               wr_allowed;    // writer holds access right

  // decode of the access
  assign hit        = acc_valid && (acc_addr == `CCU_CTRL_OFFSET);
  assign wr_allowed = access_ctrl[acc_cpu];

  // read view: reserved bits, and the tag ECC bit when ECC is not built in, read zero
  always_comb begin
    rd_word = ctrl & `CCU_CTRL_WR_MASK;
    if (!ECC_IMPL) begin
      rd_word[`CCU_BIT_TAG_ECC] = 1'b0;
    end
    rd_word[`CCU_BIT_FILTER] = filt_flag;
  end

  // byte merge: only enabled lanes take new data
  always_comb begin
    wr_merge = ctrl;
    for (int b = 0; b < 4; b++) begin
      if (acc_be[b]) begin
        wr_merge[b*`CCU_BYTE_W +: `CCU_BYTE_W] =
          acc_wdata[b*`CCU_BYTE_W +: `CCU_BYTE_W];
      end
    end
  end

  // next values of the register and the access answer
  always_comb begin
    next_ctrl       = ctrl;
    next_rdata      = acc_rdata;
    next_ack        = acc_ack;
    next_filt_flag  = filt_flag;
    next_filt_taken = filt_taken;
    if (ce) begin
      next_ack   = acc_valid;
      next_rdata = 32'h0000_0000;
      // a write without the access right is dropped silently
      if (hit && acc_write && wr_allowed) begin
        next_ctrl = wr_merge & `CCU_CTRL_WR_MASK;
        if (!ECC_IMPL) begin
          next_ctrl[`CCU_BIT_TAG_ECC] = 1'b0;
        end
      end
      // unmapped reads return zero
      if (hit && !acc_write) begin
        next_rdata = rd_word;
      end
      // strap is caught on the first enabled edge after release
      if (!filt_taken) begin
        next_filt_taken = 1'b1;
        next_filt_flag  = master_filter_enable_input && TWO_MASTERS;
      end
    end
  end

  // register file flops, all cleared by the unit reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl       <= `CCU_CTRL_RESET;
      acc_rdata  <= 32'h0000_0000;
      acc_ack    <= 1'b0;
      filt_flag  <= 1'b0;
      filt_taken <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      acc_rdata  <= next_rdata;
      acc_ack    <= next_ack;
      filt_flag  <= next_filt_flag;
      filt_taken <= next_filt_taken;
    end
  end

  // ---------------------------------------------------------------
  // standby gating of the unit and interrupt controller clocks
  // ---------------------------------------------------------------
  logic unit_idle;   // every processor asleep, nothing pending
  logic unit_wake;   // reason to restart the unit clock
  logic ic_idle;     // no interrupt and no processor request
  logic unit_run;    // unit clock enable from its controller
  logic ic_run;      // interrupt controller clock enable

  // accelerator requests only count when that port exists
  assign unit_idle = (&cpu_wait_for_interrupt_state)
                   && !(ACP_IMPL && accel_req_pending)
                   && !unit_busy;
  assign unit_wake = !(&cpu_wait_for_interrupt_state)
                   || (ACP_IMPL && accel_new_req);
  assign ic_idle   = !irq_pending && !(|cpu_rw_pending);

  // unit clock standby
  ccu_standby_gate u_unit_gate (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .enable (ctrl[`CCU_BIT_STANDBY]),
    .idle   (unit_idle),
    .wake   (unit_wake),
    .clk_en (unit_run)
  );

  // interrupt controller standby, wakes as soon as it is not idle
  ccu_standby_gate u_ic_gate (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .enable (ctrl[`CCU_BIT_IC_STANDBY]),
    .idle   (ic_idle),
    .wake   (!ic_idle),
    .clk_en (ic_run)
  );

  // ---------------------------------------------------------------
  // speculative linefills
  // ---------------------------------------------------------------
  logic spec_go;        // this linefill goes out speculatively
  logic spec_port1;     // speculative target is master port 1
  logic spec_pend;      // speculative linefill awaits its lookup
  logic next_spec_pend;
  logic spec_pend_m1;   // port of the pending linefill
  logic next_spec_pend_m1;
  logic next_spec_m0;
  logic next_spec_m1;
  logic next_conf_m0;
  logic next_conf_m1;

  // without the level-2 controller the enable does nothing
  assign spec_go    = lf_req && ctrl[`CCU_BIT_SPEC_LF] && L2_PRESENT;
  // filtering pins speculation to port 0
  assign spec_port1 = lf_to_m1 && !filt_flag && TWO_MASTERS;

  // issue speculation with the lookup, confirm on a miss
  always_comb begin
    next_spec_pend    = spec_pend;
    next_spec_pend_m1 = spec_pend_m1;
    next_spec_m0      = spec_lf_m0;
    next_spec_m1      = spec_lf_m1;
    next_conf_m0      = confirm_lf_m0;
    next_conf_m1      = confirm_lf_m1;
    if (ce) begin
      next_spec_m0 = spec_go && !spec_port1;
      next_spec_m1 = spec_go && spec_port1;
      next_conf_m0 = 1'b0;
      next_conf_m1 = 1'b0;
      // a hit simply retires the speculation
      if (spec_pend && lookup_done) begin
        next_spec_pend = 1'b0;
        next_conf_m0   = lookup_miss && !spec_pend_m1;
        next_conf_m1   = lookup_miss && spec_pend_m1;
      end
      // a new speculative linefill wins over retirement
      if (spec_go) begin
        next_spec_pend    = 1'b1;
        next_spec_pend_m1 = spec_port1;
      end
    end
  end

  // linefill flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spec_pend     <= 1'b0;
      spec_pend_m1  <= 1'b0;
      spec_lf_m0    <= 1'b0;
      spec_lf_m1    <= 1'b0;
      confirm_lf_m0 <= 1'b0;
      confirm_lf_m1 <= 1'b0;
    end else begin
      spec_pend     <= next_spec_pend;
      spec_pend_m1  <= next_spec_pend_m1;
      spec_lf_m0    <= next_spec_m0;
      spec_lf_m1    <= next_spec_m1;
      confirm_lf_m0 <= next_conf_m0;
      confirm_lf_m1 <= next_conf_m1;
    end
  end

  // ---------------------------------------------------------------
  // control outputs and accelerator readies
  // ---------------------------------------------------------------
  logic next_ar_rdy;
  logic next_aw_rdy;
  logic next_w_rdy;
  logic next_unit_en;
  logic next_tag_ecc;
  logic next_ecc_acp;
  logic next_ecc_per;
  logic next_ecc_m1;
  logic next_ecc_m0;
  logic next_unit_clk;
  logic next_ic_clk;
  logic next_filter;

  // outputs follow the register one cycle later; readies use the
  // gate decision of the same cycle so that none leaks while gated
  always_comb begin
    next_ar_rdy   = accel_port_read_addr_ready;
    next_aw_rdy   = accel_port_write_addr_ready;
    next_w_rdy    = accel_port_write_data_ready;
    next_unit_en  = unit_enable;
    next_tag_ecc  = tag_ecc_enable;
    next_ecc_acp  = ecc_chk_acp;
    next_ecc_per  = ecc_chk_periph;
    next_ecc_m1   = ecc_chk_m1;
    next_ecc_m0   = ecc_chk_m0;
    next_unit_clk = unit_clk_en;
    next_ic_clk   = interrupt_ctrl_clk_en;
    next_filter   = filter_on;
    if (ce) begin
      next_ar_rdy   = accel_rd_addr_ready_in && unit_run;
      next_aw_rdy   = accel_wr_addr_ready_in && unit_run;
      next_w_rdy    = accel_wr_data_ready_in && unit_run;
      next_unit_en  = ctrl[`CCU_BIT_ENABLE];
      next_tag_ecc  = rd_word[`CCU_BIT_TAG_ECC];
      next_ecc_acp  = ctrl[`CCU_BIT_ECC_ACP] && ACP_IMPL;
      next_ecc_per  = ctrl[`CCU_BIT_ECC_PERIPH];
      next_ecc_m1   = ctrl[`CCU_BIT_ECC_M1];
      next_ecc_m0   = ctrl[`CCU_BIT_ECC_M0];
      next_unit_clk = unit_run;
      next_ic_clk   = ic_run;
      next_filter   = filt_flag;
    end
  end

  // output flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accel_port_read_addr_ready  <= 1'b0;
      accel_port_write_addr_ready <= 1'b0;
      accel_port_write_data_ready <= 1'b0;
      unit_enable                 <= 1'b0;
      tag_ecc_enable              <= 1'b0;
      ecc_chk_acp                 <= 1'b0;
      ecc_chk_periph              <= 1'b0;
      ecc_chk_m1                  <= 1'b0;
      ecc_chk_m0                  <= 1'b0;
      unit_clk_en                 <= 1'b1;
      interrupt_ctrl_clk_en       <= 1'b1;
      filter_on                   <= 1'b0;
    end else begin
      accel_port_read_addr_ready  <= next_ar_rdy;
      accel_port_write_addr_ready <= next_aw_rdy;
      accel_port_write_data_ready <= next_w_rdy;
      unit_enable                 <= next_unit_en;
      tag_ecc_enable              <= next_tag_ecc;
      ecc_chk_acp                 <= next_ecc_acp;
      ecc_chk_periph              <= next_ecc_per;
      ecc_chk_m1                  <= next_ecc_m1;
      ecc_chk_m0                  <= next_ecc_m0;
      unit_clk_en                 <= next_unit_clk;
      interrupt_ctrl_clk_en       <= next_ic_clk;
      filter_on                   <= next_filter;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/ccu_standby_gate.sv
// clock standby controller: gates a clock enable while idle
`timescale 1ns/1ps
`default_nettype none

module ccu_standby_gate (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // control
  input  wire logic enable,
  input  wire logic idle,
  input  wire logic wake,
  // clock enable to the gated domain
  output var  logic clk_en
);

  ccu_pkg::ccu_standby_e state;       // current standby state
  ccu_pkg::ccu_standby_e next_state;  // next standby state
  logic                  next_clk_en; // next clock enable

  // next state: gate when enabled and idle, reopen on wake
  always_comb begin
    next_state  = state;
    next_clk_en = clk_en;
    if (ce) begin
      unique case (state)
        ccu_pkg::CCU_RUN: begin
          if (enable && idle && !wake) begin
            next_state = ccu_pkg::CCU_GATED;
          end
        end
        ccu_pkg::CCU_GATED: begin
          // clearing the enable also reopens the clock
          if (wake || !enable) begin
            next_state = ccu_pkg::CCU_RUN;
          end
        end
        default: begin
          next_state = ccu_pkg::CCU_RUN;
        end
      endcase
      next_clk_en = (next_state == ccu_pkg::CCU_RUN);
    end
  end

  // register the state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= ccu_pkg::CCU_RUN;
      clk_en <= 1'b1;
    end else begin
      state  <= next_state;
      clk_en <= next_clk_en;
    end
  end

endmodule

`default_nettype wire

// >>> verification/ccu_ctrl_sva.sv
// assertion checker for the coherency control unit control register
`timescale 1ns/1ps
`default_nettype none

module ccu_ctrl_sva (
  // clock, reset and enable
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  // register access
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [7:0]  acc_addr,
  input wire logic [3:0]  acc_be,
  input wire logic [31:0] acc_wdata,
  input wire logic        acc_cpu,
  input wire logic [1:0]  access_ctrl,
  input wire logic [31:0] acc_rdata,
  input wire logic        acc_ack,
  // standby and accelerator port
  input wire logic [1:0]  cpu_wait_for_interrupt_state,
  input wire logic        accel_port_read_addr_ready,
  input wire logic        accel_port_write_addr_ready,
  input wire logic        accel_port_write_data_ready,
  input wire logic        unit_clk_en,
  // linefill
  input wire logic        lookup_done,
  input wire logic        lookup_miss,
  input wire logic        spec_lf_m1,
  input wire logic        confirm_lf_m0,
  // control outputs
  input wire logic        filter_on,
  input wire logic        unit_enable,
  input wire logic        tag_ecc_enable,
  input wire logic        ecc_chk_acp,
  input wire logic        ecc_chk_periph,
  input wire logic        ecc_chk_m1,
  input wire logic        ecc_chk_m0
);
  // control outputs in register bit order
  wire logic [5:0] ctl = {ecc_chk_acp, ecc_chk_periph, ecc_chk_m1, ecc_chk_m0,
                          tag_ecc_enable, unit_enable};
  // a write that goes to the register
  wire logic       wr = ce && acc_valid && acc_write && acc_addr == 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_ack; ce && acc_valid |=> acc_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  // a permitted write on both low lanes lands two edges later
  property p_wr; wr && acc_be[1:0] == 2'b11 && access_ctrl[acc_cpu] ##1 ce
    |=> ctl == {$past(acc_wdata[15:12], 2), $past(acc_wdata[2], 2), $past(acc_wdata[0], 2)};
  endproperty
  a_wr: assert property (p_wr) else $error("write not applied");
  property p_refuse; wr && !access_ctrl[acc_cpu] ##1 ce |=> $stable(ctl); endproperty
  a_refuse: assert property (p_refuse) else $error("refused write changed control");
  property p_rsvd; acc_ack |-> (acc_rdata & 32'hFFFF_0F90) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_unmap; ce && acc_valid && acc_addr != 8'h00 |=> acc_rdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_gated; !unit_clk_en |-> !(accel_port_read_addr_ready ||
    accel_port_write_addr_ready || accel_port_write_data_ready); endproperty
  a_gated: assert property (p_gated) else $error("ready high while gated");
  // leaving the sleep state restarts the unit clock
  property p_wake; (ce && !(&cpu_wait_for_interrupt_state))[*2] ##1 ce |=> unit_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("unit clock not restarted");
  property p_filt_m1; spec_lf_m1 |-> !filter_on; endproperty
  a_filt_m1: assert property (p_filt_m1) else $error("speculation sent to port 1");
  property p_conf; confirm_lf_m0 |-> $past(lookup_done && lookup_miss); endproperty
  a_conf: assert property (p_conf) else $error("confirm without miss");
  property p_filt_hold; filter_on |=> filter_on; endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter flag lost");

  c_wr: cover property (wr && access_ctrl[acc_cpu]);
  c_gated: cover property (!unit_clk_en);
  c_conf: cover property (confirm_lf_m0);
endmodule

bind ccu_ctrl_reg ccu_ctrl_sva u_sva (.*);

`default_nettype wire

// >>> verification/testbench.sv
// self-checking testbench for the coherency control unit control register
`include "ccu_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // design ports
  logic        clk, arst_n, ce, acc_valid, acc_write, acc_cpu, acc_ack;
  logic [7:0]  acc_addr;
  logic [3:0]  acc_be;
  logic [31:0] acc_wdata, acc_rdata;
  logic [1:0]  access_ctrl, cpu_wait_for_interrupt_state, cpu_rw_pending;
  logic        master_filter_enable_input, accel_req_pending, accel_new_req, unit_busy;
  logic        irq_pending, accel_rd_addr_ready_in, accel_wr_addr_ready_in;
  logic        accel_wr_data_ready_in, accel_port_read_addr_ready;
  logic        accel_port_write_addr_ready, accel_port_write_data_ready;
  logic        lf_req, lf_to_m1, lookup_done, lookup_miss, spec_lf_m0, spec_lf_m1;
  logic        confirm_lf_m0, confirm_lf_m1, unit_enable, tag_ecc_enable, filter_on;
  logic        ecc_chk_acp, ecc_chk_periph, ecc_chk_m1, ecc_chk_m0;
  logic        unit_clk_en, interrupt_ctrl_clk_en;
  // bench state
  logic [31:0] model;      // expected register contents
  logic [32:0] exp_q[$];   // notes: compare flag and read data
  logic [32:0] e;          // note being compared
  logic [2:0]  rdy_in;     // random readies offered by the datapath
  int          fail_count;
  int          checks;
  wire logic [2:0] rdy = {accel_port_read_addr_ready, accel_port_write_addr_ready,
                          accel_port_write_data_ready};
  wire logic [5:0] ctl = {ecc_chk_acp, ecc_chk_periph, ecc_chk_m1, ecc_chk_m0,
                          tag_ecc_enable, unit_enable};

  ccu_ctrl_reg dut (.*);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // counted comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  // expected control outputs: filter flag, port checks, tag ECC, enable
  function automatic logic [31:0] exp_outs;
    return 32'({model[1], model[15:12], model[2], model[0]});
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // reset for 20 cycles; strap changes after capture to prove it is held
  task automatic rst(input logic s);
    arst_n = 1'b0;
    master_filter_enable_input = s;
    repeat (20) @(negedge clk);
    chk("reset levels", 32'h3, 32'({filter_on, ctl, rdy, unit_clk_en, interrupt_ctrl_clk_en}));
    arst_n = 1'b1;
    model = 32'({s, 1'b0});
    @(negedge clk);
    master_filter_enable_input = ~s;
  endtask

  // one access; valid stays up so accesses run back to back
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic cpu);
    {acc_valid, acc_write, acc_addr, acc_be, acc_wdata, acc_cpu} = {1'b1, w, a, be, d, cpu};
    if (w) begin
      exp_q.push_back(33'h0);
      for (int i = 0; i < 4; i++) begin
        // bits that software cannot write keep their value, the filter flag too
        if (a == 8'h00 && access_ctrl[cpu] && be[i]) begin
          model[8*i+:8] = 8'((d[8*i+:8] & (`CCU_CTRL_WR_MASK >> (8*i)))
                          | (model[8*i+:8] & ~(`CCU_CTRL_WR_MASK >> (8*i))));
        end
      end
    end else begin
      exp_q.push_back({1'b1, a == 8'h00 ? model : 32'h0});
    end
    @(negedge clk);
  endtask

  task automatic idle;
    acc_valid = 1'b0;
    @(negedge clk);
  endtask

  // bounded wait for a clock enable level; running out ends the run
  task automatic wait_en(input bit ic, input logic v);
    int n;
    n = 0;
    while ((ic ? interrupt_ctrl_clk_en : unit_clk_en) !== v) begin
      @(negedge clk);
      n++;
      if (n > 10) begin
        chk("clock enable", 32'(v), 32'(~v));
        report_and_stop;
      end
    end
  endtask

  // linefill then lookup; exp is {spec m1, spec m0, confirm m1, confirm m0}
  task automatic lf(input logic m1, input logic miss, input logic [3:0] exp);
    {lf_req, lf_to_m1} = {1'b1, m1};
    @(negedge clk);
    lf_req = 1'b0;
    chk("spec linefill", 32'(exp[3:2]), 32'({spec_lf_m1, spec_lf_m0}));
    {lookup_done, lookup_miss} = {1'b1, miss};
    @(negedge clk);
    lookup_done = 1'b0;
    chk("confirm linefill", 32'(exp[1:0]), 32'({confirm_lf_m1, confirm_lf_m0}));
  endtask

  // each acknowledge takes the oldest note; sampled mid-cycle, where it is settled
  always @(negedge clk) begin
    if (arst_n === 1'b1 && acc_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("acc_ack", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        if (e[32]) begin
          chk("acc_rdata", e[31:0], acc_rdata);
        end
      end
    end
  end

  // hang guard, about 100000 cycles
  initial begin
    #2_500_000;
    chk("run time", 32'h0, 32'h1);
    report_and_stop;
  end

  initial begin
    {acc_valid, acc_write, acc_cpu, acc_addr, acc_be, acc_wdata, cpu_rw_pending} = '0;
    {irq_pending, lf_req, lf_to_m1, lookup_done, lookup_miss, accel_req_pending} = '0;
    {accel_new_req, unit_busy, fail_count, checks} = '0;
    {accel_rd_addr_ready_in, accel_wr_addr_ready_in, accel_wr_data_ready_in} = 3'b111;
    {clk, arst_n, ce, access_ctrl, cpu_wait_for_interrupt_state} = 7'b0011100;
    void'($urandom(32'hb61867f7));
    rst(1'b1);
    acc(1'b0, 8'h00, 4'h0, 32'h0, 1'b0);
    // random byte writes from either processor, read back at once
    repeat (24) begin
      access_ctrl = 2'($urandom);
      acc(1'b1, 8'h00, 4'($urandom), $urandom, 1'($urandom));
      acc(1'b0, 8'h00, 4'h0, 32'h0, 1'b0);
      idle;
      chk("outputs", exp_outs(), 32'({filter_on, ctl}));
    end
    access_ctrl = 2'b11;
    // clock enable low: a write is neither taken nor answered
    ce = 1'b0;
    {acc_valid, acc_write, acc_addr, acc_be, acc_wdata} = {2'b11, 8'h00, 4'hf, ~model};
    repeat (3) @(negedge clk);
    ce = 1'b1;
    idle;
    chk("frozen outputs", exp_outs(), 32'({filter_on, ctl}));
    acc(1'b1, 8'h04, 4'hf, 32'hffff_ffff, 1'b1);
    acc(1'b0, 8'h04, 4'h0, 32'h0, 1'b0);
    acc(1'b1, 8'h00, 4'hf, 32'hffff_ffff, 1'b0);
    acc(1'b0, 8'h00, 4'h0, 32'h0, 1'b0);
    acc(1'b1, 8'h00, 4'hf, 32'h0000_0069, 1'b0);
    idle;
    rdy_in = 3'($urandom);
    {accel_rd_addr_ready_in, accel_wr_addr_ready_in, accel_wr_data_ready_in} = rdy_in;
    // standby: activity holds the clock, idle gates it, wake restarts it
    {unit_busy, cpu_wait_for_interrupt_state} = 3'b111;
    repeat (6) @(negedge clk);
    chk("clock while busy", 32'h1, 32'(unit_clk_en));
    unit_busy = 1'b0;
    wait_en(1'b0, 1'b0);
    wait_en(1'b1, 1'b0);
    chk("readies gated", 32'h0, 32'(rdy));
    accel_new_req = 1'b1;
    wait_en(1'b0, 1'b1);
    chk("readies awake", 32'(rdy_in), 32'(rdy));
    accel_new_req = 1'b0;
    wait_en(1'b0, 1'b0);
    cpu_wait_for_interrupt_state = 2'b01;
    wait_en(1'b0, 1'b1);
    {accel_req_pending, cpu_wait_for_interrupt_state} = 3'b111;
    repeat (6) @(negedge clk);
    chk("clock while port busy", 32'h1, 32'(unit_clk_en));
    {accel_req_pending, cpu_rw_pending} = 3'b010;
    wait_en(1'b1, 1'b1);
    cpu_rw_pending = 2'b00;
    wait_en(1'b1, 1'b0);
    {irq_pending, cpu_wait_for_interrupt_state} = 3'b100;
    wait_en(1'b1, 1'b1);
    acc(1'b1, 8'h00, 4'h1, 32'h0000_0009, 1'b0);
    idle;
    {irq_pending, cpu_wait_for_interrupt_state} = 3'b011;
    repeat (6) @(negedge clk);
    chk("clocks free", 32'h3, 32'({unit_clk_en, interrupt_ctrl_clk_en}));
    lf(1'b1, 1'b1, 4'b0101);
    lf(1'b0, 1'b0, 4'b0100);
    rst(1'b0);
    acc(1'b0, 8'h00, 4'h0, 32'h0, 1'b0);
    acc(1'b1, 8'h00, 4'h1, 32'h0000_0008, 1'b1);
    idle;
    lf(1'b1, 1'b1, 4'b1010);
    acc(1'b1, 8'h00, 4'h1, 32'h0, 1'b0);
    idle;
    lf(1'b0, 1'b1, 4'b0000);
    chk("unanswered", 32'h0, 32'(exp_q.size()));
    report_and_stop;
  end
endmodule

`default_nettype wire
